// file: core/rcc_regs.vh
// Register map constants for the retimer channel tuning register block.
// Assumes a byte-wide register access port with a per-channel select.
`ifndef RCC_REGS_VH
`define RCC_REGS_VH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define RCC_OFF_TOL_TAP1      8'h35
`define RCC_OFF_REF_CAP       8'h36
`define RCC_OFF_LEQ_STATUS    8'h37
`define RCC_OFF_FBEQ_STATUS   8'h38
`define RCC_OFF_FERR_HI       8'h3b
`define RCC_OFF_FERR_LO       8'h3c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define RCC_TOL_SCALE_HI      7
`define RCC_TOL_SCALE_LO      6
`define RCC_CAPTURE_BIT       5
`define RCC_TAP1_HI           4
`define RCC_TAP1_LO           0
`define RCC_EYE_IRQ_BIT       6
`define RCC_REF_MODE_HI       5
`define RCC_REF_MODE_LO       4
`define RCC_CAP_OV_BIT        2
`define RCC_CAP_RNG_HI        1
`define RCC_CAP_RNG_LO        0
`define RCC_RST_TOL_TAP1      8'h1f
`define RCC_RST_REF_CAP       8'h31
`define RCC_RST_STATUS        8'h00
`define RCC_NUM_CH            4

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define RCC_REF_FAST_FULL     2'h3
`define RCC_REF_CONSTR_REF    2'h2
`define RCC_REF_LESS_CONSTR   2'h1
`define RCC_REF_LESS_FULL     2'h0
`define RCC_TOL_KEEP          2'h0
`define RCC_TOL_ADD           2'h1
`define RCC_TOL_DOUBLE        2'h2
`define RCC_TOL_DOUBLE_ADD    2'h3

`endif

// file: core/rcc_channel_regs.v
// Per-channel clock-recovery tuning registers (offsets lock_tolerance_and_tap1_limit to feedback_equalizer_status) for four channels.
// Assumes one-cycle write and read strobes from the management serial port decoder,
// and a frequency error engine that answers a capture request with a done pulse.
//
// Overview of operation
// RQ1 - Scale field keeps, adds bits 3:1, doubles, or doubles-and-adds the tolerance.
// RQ2 - Writing capture bit requests a frequency error capture; bit clears when done.
// RQ3 - Frequency error result refreshes continuously; capture bit forces a single update.
// RQ4 - Five-bit first-tap limit in bits 4:0 of lock_tolerance_and_tap1_limit, resets to all ones.
// RQ5 - Bit 6 of reference_and_cap_range_control enables eye-opening interrupts; zero blocks them.
// RQ6 - Reference-mode field selects one of four clock-recovery search methods.
// RQ7 - Bit 2 of reference_and_cap_range_control makes register cap DAC range override default.
// RQ8 - Cap DAC stop equals start minus (range+1); range resets to 01.
// RQ9 - Status bytes at linear_equalizer_status and feedback_equalizer_status are read-only and read zero.
// RQ10 - Ready flag rises when a frequency error count is available.
// RQ11 - Each channel holds an independent copy of all these registers.
`timescale 1ns/1ns
`include "rcc_regs.vh"

module rcc_channel_regs
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire [1:0]  ch_sel,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire        reg_hit,
  input  wire [31:0] ppm_delta_in,
  output wire [31:0] ppm_delta_scaled,
  input  wire [3:0]  ferr_done,
  input  wire [31:0] ferr_count,
  output wire [3:0]  ferr_capture_req,
  output wire [3:0]  ferr_continuous,
  output wire [3:0]  ferr_ready,
  output wire [19:0] fb_eq_first_tap_limit,
  input  wire [3:0]  eye_opening_event,
  output wire [3:0]  eye_opening_irq,
  output wire [7:0]  ref_mode,
  output wire [3:0]  ref_clock_used,
  output wire [3:0]  cap_full_search,
  input  wire [19:0] cap_start,
  input  wire [19:0] cap_default_stop,
  output wire [19:0] cap_stop
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [7:0] rcc_scale_tol;
    input [1:0] code;
    input [7:0] tol;
    begin
      case (code)
        `RCC_TOL_ADD:    rcc_scale_tol = tol + {5'h00, tol[3:1]};
        `RCC_TOL_DOUBLE: rcc_scale_tol = {tol[6:0], 1'b0};
        `RCC_TOL_DOUBLE_ADD:
                         rcc_scale_tol = {tol[6:0], 1'b0} + {5'h00, tol[3:1]};
        default:         rcc_scale_tol = tol;
      endcase
    end
  endfunction

  function [4:0] rcc_cap_stop;
    input [4:0] start;
    input [1:0] rng;
    begin
      rcc_cap_stop = start - {2'h0, rng} - 5'h01;
    end
  endfunction

  // One channel copy is touched per strobe; the others keep their state
  function rcc_ch_hit;
    input       strobe;
    input [1:0] sel;
    input [1:0] idx;
    input [7:0] addr;
    input [7:0] off;
    begin
      rcc_ch_hit = strobe && sel == idx && addr == off;
    end
  endfunction

  // ----------------------------------------------------------------
  // Per-channel storage
  // ----------------------------------------------------------------
  reg [7:0] tol_tap1_reg [0:3];
  reg [7:0] ref_cap_reg  [0:3];
  reg [3:0] ready_reg;
  reg [15:0] ferr_hold_reg [0:3];
  reg       hit_w;
  integer   i;
  integer   j;

  always @*
  begin
    if (reg_addr == `RCC_OFF_TOL_TAP1)
      hit_w = 1'b1;
    else if (reg_addr == `RCC_OFF_REF_CAP)
      hit_w = 1'b1;
    else if (reg_addr == `RCC_OFF_LEQ_STATUS)
      hit_w = 1'b1;
    else if (reg_addr == `RCC_OFF_FBEQ_STATUS)
      hit_w = 1'b1;
    else if (reg_addr == `RCC_OFF_FERR_HI)
      hit_w = 1'b1;
    else if (reg_addr == `RCC_OFF_FERR_LO)
      hit_w = 1'b1;
    else
      hit_w = 1'b0;
  end
  assign reg_hit = hit_w;

  always @(posedge clock)
  begin
    for (i = 0; i < `RCC_NUM_CH; i = i + 1)
    begin
      if (!rst_n)
      begin
        tol_tap1_reg[i] <= `RCC_RST_TOL_TAP1;   // [RQ4]
        ref_cap_reg[i]  <= `RCC_RST_REF_CAP;    // [RQ8]
      end
      else
      begin
        // Only the selected channel's copy takes a write [RQ11]
        // A write in the completion cycle wins, so a fresh request is never lost
        if (rcc_ch_hit(reg_wr, ch_sel, i[1:0], reg_addr, `RCC_OFF_TOL_TAP1))
          tol_tap1_reg[i] <= reg_wdata;
        else if (ferr_done[i])
          tol_tap1_reg[i][`RCC_CAPTURE_BIT] <= 1'b0;     // [RQ2]
        if (rcc_ch_hit(reg_wr, ch_sel, i[1:0], reg_addr, `RCC_OFF_REF_CAP))
          ref_cap_reg[i] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frequency error result
  // ----------------------------------------------------------------
  // Every completion refreshes the result, zero included, so continuous and
  // single updates share one path; a new result wins over the read-clear
  always @(posedge clock)
  begin
    for (j = 0; j < `RCC_NUM_CH; j = j + 1)
    begin
      if (!rst_n)
      begin
        ready_reg[j]     <= 1'b0;
        ferr_hold_reg[j] <= 16'h0000;
      end
      else if (ferr_done[j])
      begin
        ferr_hold_reg[j] <= {8'h00, ferr_count[j*8 +: 8]};   // [RQ3]
        ready_reg[j]     <= 1'b1;                            // [RQ10]
      end
      else if (rcc_ch_hit(reg_rd, ch_sel, j[1:0], reg_addr, `RCC_OFF_FERR_LO))
        ready_reg[j] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the channel datapath
  // ----------------------------------------------------------------
  // Datapath controls follow the stored bytes with no extra delay
  genvar g;
  generate
    for (g = 0; g < `RCC_NUM_CH; g = g + 1)
    begin : ch
      assign ppm_delta_scaled[g*8 +: 8] =
        rcc_scale_tol(tol_tap1_reg[g][`RCC_TOL_SCALE_HI:`RCC_TOL_SCALE_LO],
                      ppm_delta_in[g*8 +: 8]);                                // [RQ1]
      assign ferr_capture_req[g] = tol_tap1_reg[g][`RCC_CAPTURE_BIT];          // [RQ2]
      assign ferr_continuous[g]  = ~tol_tap1_reg[g][`RCC_CAPTURE_BIT];         // [RQ3]
      assign ferr_ready[g]       = ready_reg[g];                               // [RQ10]
      assign fb_eq_first_tap_limit[g*5 +: 5] =
        tol_tap1_reg[g][`RCC_TAP1_HI:`RCC_TAP1_LO];                            // [RQ4]
      assign eye_opening_irq[g] =
        eye_opening_event[g] & ref_cap_reg[g][`RCC_EYE_IRQ_BIT];               // [RQ5]
      assign ref_mode[g*2 +: 2] = ref_cap_reg[g][`RCC_REF_MODE_HI:`RCC_REF_MODE_LO];
      assign ref_clock_used[g]  = ref_cap_reg[g][`RCC_REF_MODE_HI];            // [RQ6]
      assign cap_full_search[g] =
        ref_cap_reg[g][`RCC_REF_MODE_HI:`RCC_REF_MODE_LO] == `RCC_REF_FAST_FULL ||
        ref_cap_reg[g][`RCC_REF_MODE_HI:`RCC_REF_MODE_LO] == `RCC_REF_LESS_FULL; // [RQ6]
      assign cap_stop[g*5 +: 5] = ref_cap_reg[g][`RCC_CAP_OV_BIT] ?
        rcc_cap_stop(cap_start[g*5 +: 5],
                     ref_cap_reg[g][`RCC_CAP_RNG_HI:`RCC_CAP_RNG_LO]) :          // [RQ8]
        cap_default_stop[g*5 +: 5];                                            // [RQ7]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `RCC_OFF_TOL_TAP1)
        reg_rdata <= tol_tap1_reg[ch_sel];
      else if (reg_addr == `RCC_OFF_REF_CAP)
        reg_rdata <= ref_cap_reg[ch_sel];
      else if (reg_addr == `RCC_OFF_FERR_HI)
        reg_rdata <= ferr_hold_reg[ch_sel][15:8];
      else if (reg_addr == `RCC_OFF_FERR_LO)
        reg_rdata <= ferr_hold_reg[ch_sel][7:0];
      else if (reg_addr == `RCC_OFF_LEQ_STATUS)
        reg_rdata <= `RCC_RST_STATUS;     // Reserved status reads zero [RQ9]
      else if (reg_addr == `RCC_OFF_FBEQ_STATUS)
        reg_rdata <= `RCC_RST_STATUS;     // [RQ9]
      // Unmapped offsets read zero, so probing software sees no stale data
      else
        reg_rdata <= `RCC_RST_STATUS;
    end
  end

endmodule

// file: tb/rcc_chk.sv
// Assertions for the channel tuning register block.
// Bound to the block; sees its ports only.
`timescale 1ns/1ns
module rcc_chk
(
  input wire logic        clock, rst_n, reg_rd, reg_wr,
  input wire logic [1:0]  ch_sel,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, ref_mode,
  input wire logic [3:0]  ferr_done, ferr_capture_req, ferr_continuous,
  input wire logic [3:0]  eye_opening_event, eye_opening_irq, ref_clock_used,
  input wire logic [3:0]  cap_full_search,
  input wire logic [19:0] fb_eq_first_tap_limit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_cont_inverse: assert property (ferr_continuous == ~ferr_capture_req)
    else $error("continuous flag wrong");
  a_irq_gated: assert property ((eye_opening_irq & ~eye_opening_event) == 4'h0)
    else $error("irq without event");
  a_ref_clock: assert property (ref_clock_used ==
    {ref_mode[7], ref_mode[5], ref_mode[3], ref_mode[1]}) else $error("ref clock wrong");
  a_full_search: assert property (cap_full_search[0] == (ref_mode[1] == ref_mode[0]))
    else $error("full search wrong");
  a_done_clears: assert property (ferr_done != 4'h0 && !reg_wr |=>
    (ferr_capture_req & $past(ferr_done)) == 4'h0) else $error("capture not cleared");
  a_capture_set: assert property (reg_wr && reg_addr == 8'h35 && reg_wdata[5] &&
    ferr_done == 4'h0 |=> ferr_capture_req[$past(ch_sel)]) else $error("capture not set");
  a_tap_write: assert property (reg_wr && reg_addr == 8'h35 |=>
    fb_eq_first_tap_limit[5*$past(ch_sel)+:5] == $past(reg_wdata[4:0])) else $error("tap");
  a_status_zero: assert property (reg_rd && reg_addr inside {8'h37, 8'h38} |=>
    reg_rdata == 8'h00) else $error("status not zero");
  a_reset_vals: assert property ($rose(rst_n) |-> fb_eq_first_tap_limit == 20'hfffff &&
    ref_mode == 8'hff) else $error("reset values wrong");
endmodule
bind rcc_channel_regs rcc_chk i_rcc_chk(.clock, .rst_n, .reg_rd, .reg_wr, .ch_sel, .reg_addr,
  .reg_wdata, .reg_rdata, .ref_mode, .ferr_done, .ferr_capture_req, .ferr_continuous,
  .eye_opening_event, .eye_opening_irq, .ref_clock_used, .cap_full_search,
  .fb_eq_first_tap_limit);

// file: tb/testbench.sv
// Self-checking bench for the channel tuning registers.
// Drives the register strobes and side inputs directly.
`timescale 1ns/1ns
module testbench;
  reg         clock, rst_n, reg_wr, reg_rd;
  reg  [1:0]  ch_sel, ch, a;
  reg  [7:0]  reg_addr, reg_wdata, d;
  reg  [31:0] ppm_delta_in, ferr_count, lf;
  reg  [3:0]  ferr_done, eye_opening_event;
  reg  [19:0] cap_start, cap_default_stop;
  reg  [7:0]  m35 [0:3];
  reg  [7:0]  m36 [0:3];
  wire [7:0]  reg_rdata, ref_mode;
  wire        reg_hit;
  wire [31:0] ppm_delta_scaled;
  wire [3:0]  ferr_capture_req, ferr_continuous, ferr_ready, eye_opening_irq;
  wire [3:0]  ref_clock_used, cap_full_search;
  wire [19:0] fb_eq_first_tap_limit, cap_stop;
  integer     mismatches = 0, total_checks = 0, i, c;
  rcc_channel_regs i_rcc_channel_regs(.clock, .rst_n, .ch_sel, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_hit, .ppm_delta_in, .ppm_delta_scaled,
    .ferr_done, .ferr_count, .ferr_capture_req, .ferr_continuous, .ferr_ready,
    .fb_eq_first_tap_limit, .eye_opening_event, .eye_opening_irq, .ref_mode,
    .ref_clock_used, .cap_full_search, .cap_start, .cap_default_stop, .cap_stop);
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [95:0] n, input [31:0] e, g);
  begin
    total_checks = total_checks + 1;
    if (e !== g)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0s exp %h got %h", n, e, g);
    end
  end
  endtask
  // One strobe cycle; side inputs get fresh random values on the same edge
  task acc(input w, input [1:0] k, input [7:0] ad, dt);
  begin
    @(posedge clock);
    {reg_wr, reg_rd, ch_sel, reg_addr, reg_wdata} <= {w, !w, k, ad, dt};
    lf = nx(lf);
    {ppm_delta_in, cap_start, cap_default_stop, eye_opening_event} <=
      {lf, lf[19:0], ~lf[19:0], lf[7:4]};
    @(posedge clock);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
  end
  endtask
  task cmp;
    reg [7:0] t;
    reg [31:0] ep;
    reg [19:0] et, es;
    reg [7:0] em;
    reg [3:0] ei, eq, er, ef, ec;
  begin
    for (c = 0; c < 4; c = c + 1)
    begin
      t = ppm_delta_in[8*c+:8];
      ep[8*c+:8] = (m35[c][7] ? {t[6:0], 1'b0} : t) + (m35[c][6] ? t[3:1] : 3'h0);
      {et[5*c+:5], em[2*c+:2], ei[c], eq[c]} = {m35[c][4:0], m36[c][5:4],
        eye_opening_event[c] & m36[c][6], m35[c][5]};
      es[5*c+:5] = m36[c][2] ? cap_start[5*c+:5] - m36[c][1:0] - 5'h01
        : cap_default_stop[5*c+:5];
      {er[c], ef[c], ec[c]} = {m36[c][5], m36[c][5] == m36[c][4], ~m35[c][5]};
    end
    chk("scaled", ep, ppm_delta_scaled);
    chk("tap", et, fb_eq_first_tap_limit);
    chk("irq", ei, eye_opening_irq);
    chk("mode", em, ref_mode);
    chk("stop", es, cap_stop);
    chk("capture", eq, ferr_capture_req);
    chk("refclk", er, ref_clock_used);
    chk("full", ef, cap_full_search);
    chk("cont", ec, ferr_continuous);
  end
  endtask
  // Read back the four bytes at 8'h35 to 8'h38 of every channel, which also shows channel isolation
  task rd_all;
    for (i = 0; i < 16; i = i + 1)
    begin
      acc(0, i[3:2], 8'h35 + i[1:0], 8'h00);
      chk("rdata", i[1] ? 8'h00 : i[0] ? m36[i[3:2]] : m35[i[3:2]], reg_rdata);
      chk("hit", 1'b1, reg_hit);
    end
  endtask
  task stop_test;
  begin
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    repeat (4000) @(posedge clock);
    mismatches = mismatches + 1;
    stop_test;
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, ch_sel, reg_addr, reg_wdata, ferr_done, ferr_count} = 0;
    {ppm_delta_in, cap_start, cap_default_stop, eye_opening_event} = 0;
    lf = 32'h6817;
    for (c = 0; c < 4; c = c + 1)
      {m35[c], m36[c]} = 16'h1f31;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd_all;
    // Capture bit kept off here; writes to status bytes must be ignored
    repeat (24)
    begin
      lf = nx(lf);
      {ch, a, d} = {lf[11:8], lf[7:0] & 8'hdf};
      acc(1, ch, 8'h35 + a, d);
      if (a == 2'h0) m35[ch] = d;
      if (a == 2'h1) m36[ch] = d;
      cmp;
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      m35[i] = {i[1:0], 6'h0a};
      m36[i] = {2'b01, i[1:0], 2'b01, i[1:0]};
      acc(1, i[1:0], 8'h35, m35[i]);
      acc(1, i[1:0], 8'h36, m36[i]);
      cmp;
    end
    rd_all;
    m35[1] = 8'h3f;
    acc(1, 2'h1, 8'h35, 8'h3f);
    cmp;
    @(posedge clock);
    {ferr_done, ferr_count} <= {4'h2, 32'h00005a00};
    @(posedge clock);
    ferr_done <= 4'h0;
    #1;
    m35[1] = 8'h1f;
    chk("ready", 4'h2, ferr_ready);
    cmp;
    acc(0, 2'h1, 8'h3c, 8'h00);
    chk("ferr", 8'h5a, reg_rdata);
    chk("ready", 4'h0, ferr_ready);
    acc(0, 2'h1, 8'h3b, 8'h00);
    chk("ferr_hi", 8'h00, reg_rdata);
    // Free-running updates: a zero result must show, and channels keep apart
    @(posedge clock);
    {ferr_done, ferr_count} <= {4'h6, 32'h00330000};
    @(posedge clock);
    ferr_done <= 4'h0;
    #1;
    chk("ready", 4'h6, ferr_ready);
    acc(0, 2'h1, 8'h3c, 8'h00);
    chk("ferr_zero", 8'h00, reg_rdata);
    chk("ready", 4'h4, ferr_ready);
    acc(0, 2'h2, 8'h3c, 8'h00);
    chk("ferr_ch2", 8'h33, reg_rdata);
    acc(0, 2'h1, 8'h40, 8'h00);
    chk("unmapped", 8'h00, reg_rdata);
    chk("hit", 1'b0, reg_hit);
    // Reset in mid-run, with a completion arriving while it is held
    @(posedge clock);
    {rst_n, ferr_done, ferr_count} <= {1'b0, 4'h1, 32'h00000011};
    repeat (2) @(posedge clock);
    {rst_n, ferr_done} <= {1'b1, 4'h0};
    for (c = 0; c < 4; c = c + 1)
      {m35[c], m36[c]} = 16'h1f31;
    #1;
    chk("ready", 4'h0, ferr_ready);
    rd_all;
    cmp;
    stop_test;
  end
endmodule
